// >>> src/serial_led_shift_latch.v
// serial shift register, transparent output latch and led sink enables
// assumes all pins are asynchronous to mclk and the serial clock period
// is several mclk periods long, so every edge is seen by sampling
//
// What this block does
// - each serial clock rise shifts the data input into the 8-bit register
// - while latch load is high the output latch follows the shift register
// - latch load falling captures the shift register into the output latch
// - with latch load low the latch holds while shifting continues
// - output enable high floats all eight sinks; latch is untouched
// - output enable low lets each sink follow its latch bit
// - serial output is the register's last stage, updated on clock rise
// - reset clears register and latch; sinks float, serial output low
// - after latch load rises, bits 6 and 5 report any open led
`include "serial_led_defs.vh"
`default_nettype none

module serial_led_shift_latch #(
  parameter WORD_BITS = `SL_WORD_BITS,
  parameter FIFO_DEPTH = `SL_FIFO_DEPTH,
  parameter FAULT_CYC = `SL_FAULT_CYC
) (
  input wire mclk,
  input wire resetn,
  input wire serialClk,
  input wire serialIn,
  input wire latchLoad,
  input wire outEnableN,
  input wire [WORD_BITS-1:0] ledSinkIn,
  output wire [WORD_BITS-1:0] ledSinkOut,
  output wire [WORD_BITS-1:0] ledSinkOe,
  output wire serialOut,
  output wire eventOverrun
);

  // ****************************************************
  // input synchronisers
  // ****************************************************
  localparam SW = WORD_BITS + 4;
  localparam EW = `SL_EV_WIDTH;
  localparam S_RUN = 1'b0;
  localparam S_FAULT = 1'b1;

  reg [SW-1:0] syncA_reg;
  reg [SW-1:0] syncB_reg;
  reg clkPrev_reg;
  reg lePrev_reg;
  wire clkS;
  wire dinS;
  wire leS;
  wire oeNS;
  wire [WORD_BITS-1:0] senseS;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncA_reg <= {SW{1'b0}};
      syncB_reg <= {SW{1'b0}};
      clkPrev_reg <= 1'b0;
      lePrev_reg <= 1'b0;
    end else begin
      syncA_reg <= {ledSinkIn, outEnableN, latchLoad, serialIn, serialClk};
      syncB_reg <= syncA_reg;
      clkPrev_reg <= clkS;
      lePrev_reg <= leS;
    end
  end

  assign clkS = syncB_reg[0];
  assign dinS = syncB_reg[1];
  assign leS = syncB_reg[2];
  assign oeNS = syncB_reg[3];
  assign senseS = syncB_reg[SW-1:4];

  // ****************************************************
  // event capture into the fifo
  // ****************************************************
  wire clkRise;
  wire leRise;
  wire leFall;
  reg pendValid_reg;
  reg pendValid_next;
  reg [1:0] pendCode_reg;
  reg [1:0] pendCode_next;
  reg pushValid;
  reg [EW-1:0] pushData;
  reg overrun_reg;
  wire pushReady;

  assign clkRise = clkS && !clkPrev_reg;
  assign leRise = leS && !lePrev_reg;
  assign leFall = !leS && lePrev_reg;

  // a latch edge that meets a clock rise waits one cycle in pend, so
  // the shift is always ordered first, as the pins would order it
  always @* begin
    pushValid = 1'b0;
    pushData = {EW{1'b0}};
    pendValid_next = pendValid_reg;
    pendCode_next = pendCode_reg;
    if (pendValid_reg) begin
      pushValid = 1'b1;
      pushData = {pendCode_reg, 1'b0};
      pendValid_next = 1'b0;
    end
    if (clkRise && !pendValid_reg) begin
      pushValid = 1'b1;
      pushData = {`SL_EV_SHIFT, dinS};
    end
    if (leRise || leFall) begin
      if (pushValid) begin
        pendValid_next = 1'b1;
        pendCode_next = leRise ? `SL_EV_RISE : `SL_EV_FALL;
      end else begin
        pushValid = 1'b1;
        pushData = {(leRise ? `SL_EV_RISE : `SL_EV_FALL), 1'b0};
      end
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pendValid_reg <= 1'b0;
      pendCode_reg <= `SL_EV_SHIFT;
      overrun_reg <= 1'b0;
    end else begin
      pendValid_reg <= pendValid_next;
      pendCode_reg <= pendCode_next;
      // sticky: an event dropped on a full fifo is a lost display bit or latch edge
      if (pushValid && !pushReady) begin
        overrun_reg <= 1'b1;
      end
    end
  end

  wire popValid;
  reg popReady;
  wire [EW-1:0] popData;

  led_event_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) eventFifo (
    .mclk(mclk),
    .resetn(resetn),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );

  // ****************************************************
  // shift register, latch and fault insertion
  // ****************************************************
  reg [WORD_BITS-1:0] shift_reg;
  reg [WORD_BITS-1:0] shift_next;
  reg [WORD_BITS-1:0] latch_reg;
  reg [WORD_BITS-1:0] latch_next;
  reg latchOpen_reg;
  reg latchOpen_next;
  reg state_reg;
  reg state_next;
  reg [7:0] wait_reg;
  reg [7:0] wait_next;
  reg serialOut_reg;
  reg [WORD_BITS-1:0] sinkOe_reg;
  wire anyOpen;

  // an open led: sink commanded on while sense flags too little current
  assign anyOpen = |(latch_reg & senseS);

  always @* begin
    shift_next = shift_reg;
    latch_next = latch_reg;
    latchOpen_next = latchOpen_reg;
    state_next = state_reg;
    wait_next = wait_reg;
    popReady = 1'b0;
    case (state_reg)
      S_RUN: begin
        // draining stalls during the fault window, so the fifo can fill
        popReady = 1'b1;
        if (popValid) begin
          case (popData[EW-1:1])
            `SL_EV_SHIFT: begin
              // msb first: earlier bits move toward the top stage
              shift_next = {shift_reg[WORD_BITS-2:0], popData[0]};
            end
            `SL_EV_RISE: begin
              latchOpen_next = 1'b1;
              state_next = S_FAULT;
              wait_next = FAULT_CYC[7:0];
            end
            `SL_EV_FALL: begin
              latchOpen_next = 1'b0;
              latch_next = shift_reg;
            end
            default: begin
              latchOpen_next = latchOpen_reg;
            end
          endcase
        end
      end
      S_FAULT: begin
        if (wait_reg <= 8'h01) begin
          shift_next[`SL_FAULT_HI_POS] = anyOpen;
          shift_next[`SL_FAULT_LO_POS] = anyOpen;
          state_next = S_RUN;
        end else begin
          wait_next = wait_reg - 8'h01;
        end
      end
      default: begin
        state_next = S_RUN;
      end
    endcase
    // transparent: the latch tracks every change of the register
    if (latchOpen_next && (state_reg != S_FAULT || state_next != S_RUN)) begin
      latch_next = shift_next;
    end else if (!latchOpen_next && latchOpen_reg && state_reg == S_RUN) begin
      latch_next = shift_reg;
    end else if (!latchOpen_next) begin
      latch_next = latch_next;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= `SL_SHIFT_RESET;
      latch_reg <= `SL_LATCH_RESET;
      latchOpen_reg <= 1'b0;
      state_reg <= S_RUN;
      wait_reg <= 8'h00;
      serialOut_reg <= 1'b0;
      sinkOe_reg <= {WORD_BITS{1'b0}};
    end else begin
      shift_reg <= shift_next;
      latch_reg <= latch_next;
      latchOpen_reg <= latchOpen_next;
      state_reg <= state_next;
      wait_reg <= wait_next;
      serialOut_reg <= shift_next[WORD_BITS-1];
      // floating the sinks never touches latch_reg
      sinkOe_reg <= oeNS ? {WORD_BITS{1'b0}} : latch_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // open-drain sinks only ever pull low; enable carries the on state
  assign ledSinkOut = {WORD_BITS{1'b0}};
  assign ledSinkOe = sinkOe_reg;
  assign serialOut = serialOut_reg;
  assign eventOverrun = overrun_reg;

endmodule // serial_led_shift_latch

`default_nettype wire

// >>> src/serial_led_defs.vh
// constants of the serial shift-and-latch led sink front end
// assumes a single system clock mclk; included by bare name
`ifndef SERIAL_LED_DEFS_VH
`define SERIAL_LED_DEFS_VH

`define SL_CLK_PERIOD_NS 20
// fault sense is valid this long after the latch load rises
`define SL_FAULT_VALID_NS 20
// least time, rounded up to whole cycles, at least one
`define SL_FAULT_CYC \
  (((`SL_FAULT_VALID_NS + `SL_CLK_PERIOD_NS - 1) / `SL_CLK_PERIOD_NS) > 0 ? \
   ((`SL_FAULT_VALID_NS + `SL_CLK_PERIOD_NS - 1) / `SL_CLK_PERIOD_NS) : 1)

`define SL_WORD_BITS 8
`define SL_FAULT_HI_POS 6
`define SL_FAULT_LO_POS 5
`define SL_SHIFT_RESET 8'h00
`define SL_LATCH_RESET 8'h00

// event codes carried through the fifo, {code, data bit}
`define SL_EV_SHIFT 2'h0
`define SL_EV_RISE 2'h1
`define SL_EV_FALL 2'h2
`define SL_EV_WIDTH 3
`define SL_FIFO_DEPTH 8

`endif

// >>> src/led_event_fifo.v
// small show-ahead fifo, read data straight from a register
// assumes one clock, async active-low reset, push ignored when full
`default_nettype none

module led_event_fifo #(
  parameter WIDTH = 3,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire resetn,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  reg outValid_reg;
  reg [WIDTH-1:0] outData_reg;
  wire doPush;
  wire doLoad;

  assign inReady = (count_reg != DEPTH[AW:0]);
  assign doPush = inValid && inReady;
  // refill the output register whenever it is empty or being taken
  assign doLoad = (count_reg != {(AW+1){1'b0}}) &&
                  (!outValid_reg || outReady);
  assign outValid = outValid_reg;
  assign outData = outData_reg;

  always @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      outValid_reg <= 1'b0;
      outData_reg <= {WIDTH{1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doLoad) begin
        rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
        outData_reg <= mem[rdPtr_reg];
        outValid_reg <= 1'b1;
      end else if (outReady) begin
        outValid_reg <= 1'b0;
      end
      if (doPush && !doLoad) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (!doPush && doLoad) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // led_event_fifo

`default_nettype wire

// >>> sim/serial_led_shift_latch_chk.sv
// assertion checker for the led shift and latch front end
// assumes it sees only the top ports, all in the mclk domain
`default_nettype none
module serial_led_shift_latch_chk #(
  parameter WORD_BITS = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic latchLoad,
  input wire logic outEnableN,
  input wire logic [WORD_BITS-1:0] ledSinkIn,
  input wire logic [WORD_BITS-1:0] ledSinkOut,
  input wire logic [WORD_BITS-1:0] ledSinkOe,
  input wire logic serialOut,
  input wire logic eventOverrun
);
  logic clkPrev_reg;
  logic loadPrev_reg;
  logic [3:0] sinceEdge_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // cycles since a pin rise, saturating
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clkPrev_reg <= 1'b0;
      loadPrev_reg <= 1'b0;
      sinceEdge_reg <= 4'hf;
    end else begin
      clkPrev_reg <= serialClk;
      loadPrev_reg <= latchLoad;
      if ((serialClk && !clkPrev_reg) || (latchLoad && !loadPrev_reg))
        sinceEdge_reg <= 4'h0;
      else if (sinceEdge_reg != 4'hf)
        sinceEdge_reg <= sinceEdge_reg + 4'h1;
    end
  end
  AST_SINK_LOW: assert property (ledSinkOut == '0)
    else $error("sink drive value not low");
  AST_RESET_CLEAR: assert property ($rose(resetn) |->
    ledSinkOe == '0 && serialOut == 1'b0)
    else $error("outputs not clear after reset");
  AST_OE_BLANK: assert property (outEnableN [*5] |-> ledSinkOe == '0)
    else $error("sinks active while disabled");
  AST_OE_HOLD: assert property ((!latchLoad && !outEnableN) [*8]
    |-> $stable(ledSinkOe))
    else $error("latched sinks changed while load low");
  AST_SOUT_CAUSE: assert property ($changed(serialOut)
    |-> sinceEdge_reg <= 4'hc)
    else $error("serial out moved without a clock rise");
  AST_SOUT_IDLE: assert property ((!serialClk && !latchLoad) [*8]
    |-> $stable(serialOut))
    else $error("serial out moved while link idle");
  AST_OE_ON_CAUSE: assert property (
    (ledSinkOe & ~$past(ledSinkOe)) != '0
    |-> !$past(outEnableN, 3) || !$past(outEnableN, 4))
    else $error("sink turned on while disabled");
  AST_TRACK: assert property ((latchLoad && !outEnableN) [*8] |->
    ledSinkOe[WORD_BITS-1] == serialOut ||
    ledSinkOe[WORD_BITS-1] == $past(serialOut) ||
    ledSinkOe[WORD_BITS-1] == $past(serialOut, 2))
    else $error("open latch not following shift register");
endmodule // serial_led_shift_latch_chk

bind serial_led_shift_latch serial_led_shift_latch_chk #(
  .WORD_BITS(WORD_BITS)
) u_chk (
  .mclk(mclk), .resetn(resetn), .serialClk(serialClk),
  .serialIn(serialIn), .latchLoad(latchLoad), .outEnableN(outEnableN),
  .ledSinkIn(ledSinkIn), .ledSinkOut(ledSinkOut), .ledSinkOe(ledSinkOe),
  .serialOut(serialOut), .eventOverrun(eventOverrun)
);
`default_nettype wire

// >>> sim/led_host_model.sv
// host side model: serial clock, serial data and latch load pins
// assumes mclk from the bench; pins change on mclk falling edges
`default_nettype none
module led_host_model (
  input wire logic mclk,
  output var logic serialClk,
  output var logic serialIn,
  output var logic latchLoad
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serialClk = 1'b0;
    serialIn = 1'b0;
    latchLoad = 1'b0;
  end
  // 160 ns clock period; the clock rests low between words
  task automatic sendWord(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      repeat (2) @(negedge mclk);
      serialIn = w[i];
      repeat (2) @(negedge mclk);
      serialClk = 1'b1;
      repeat (4) @(negedge mclk);
      serialClk = 1'b0;
    end
    // released data shows the inverse rather than a held level
    serialIn = ~w[0];
  endtask
  task automatic setLoad(input logic v);
    @(negedge mclk);
    latchLoad = v;
  endtask
endmodule // led_host_model
`default_nettype wire

// >>> sim/tb_serial_led_shift_latch.sv
// self-checking bench for the led shift and latch front end
// assumes the host model drives the serial pins; bench drives the rest
`default_nettype none
module tb_serial_led_shift_latch;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic resetn;
  logic serialClk;
  logic serialIn;
  logic latchLoad;
  logic outEnableN;
  logic [7:0] ledSinkIn;
  logic [7:0] ledSinkOut;
  logic [7:0] ledSinkOe;
  logic serialOut;
  logic eventOverrun;
  int error_cnt;
  int n_tests;
  led_host_model u_host (.mclk(mclk), .serialClk(serialClk),
    .serialIn(serialIn), .latchLoad(latchLoad));
  serial_led_shift_latch u_dut (.mclk(mclk), .resetn(resetn),
    .serialClk(serialClk), .serialIn(serialIn), .latchLoad(latchLoad),
    .outEnableN(outEnableN), .ledSinkIn(ledSinkIn),
    .ledSinkOut(ledSinkOut), .ledSinkOe(ledSinkOe),
    .serialOut(serialOut), .eventOverrun(eventOverrun));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk8(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    settle(1);
    chk8("ledSinkOe", 8'h00, ledSinkOe);
    chk8("ledSinkOut", 8'h00, ledSinkOut);
    chk1("serialOut", 1'b0, serialOut);
    $display("reset test done");
  endtask
  task automatic t_shift;
    u_host.sendWord(8'ha5);
    settle(12);
    chk1("serialOut", 1'b1, serialOut);
    chk8("ledSinkOe", 8'h00, ledSinkOe);
    $display("shift test done");
  endtask
  task automatic t_load;
    u_host.setLoad(1'b1);
    settle(12);
    chk8("ledSinkOe", 8'h85, ledSinkOe);
    u_host.setLoad(1'b0);
    settle(12);
    chk8("ledSinkOe", 8'h85, ledSinkOe);
    $display("load test done");
  endtask
  task automatic t_fault;
    ledSinkIn = 8'h01;
    u_host.setLoad(1'b1);
    settle(12);
    chk8("ledSinkOe", 8'he5, ledSinkOe);
    u_host.setLoad(1'b0);
    settle(4);
    u_host.sendWord(8'h3c);
    settle(12);
    chk8("ledSinkOe", 8'he5, ledSinkOe);
    chk1("serialOut", 1'b0, serialOut);
    $display("fault test done");
  endtask
  task automatic t_blank;
    outEnableN = 1'b1;
    settle(8);
    chk8("ledSinkOe", 8'h00, ledSinkOe);
    outEnableN = 1'b0;
    settle(8);
    chk8("ledSinkOe", 8'he5, ledSinkOe);
    $display("blank test done");
  endtask
  task automatic t_track;
    ledSinkIn = 8'h00;
    u_host.setLoad(1'b1);
    settle(12);
    chk8("ledSinkOe", 8'h1c, ledSinkOe);
    u_host.sendWord(8'hf0);
    settle(12);
    chk8("ledSinkOe", 8'hf0, ledSinkOe);
    u_host.setLoad(1'b0);
    settle(12);
    u_host.sendWord(8'h0f);
    settle(12);
    chk8("ledSinkOe", 8'hf0, ledSinkOe);
    $display("track test done");
  endtask
  // shift a word, present a sense pattern, then open and close the latch
  task automatic loadWord(input logic [7:0] w, input logic [7:0] sense,
      input logic [7:0] exp);
    u_host.sendWord(w);
    settle(12);
    ledSinkIn = sense;
    u_host.setLoad(1'b1);
    settle(12);
    chk8("ledSinkOe", exp, ledSinkOe);
    u_host.setLoad(1'b0);
    settle(12);
    chk8("ledSinkOe", exp, ledSinkOe);
  endtask
  // second reset in mid-run, with a one at the serial output beforehand
  task automatic t_rerun;
    u_host.sendWord(8'h81);
    settle(12);
    chk1("serialOut", 1'b1, serialOut);
    resetn = 1'b0;
    settle(2);
    chk8("ledSinkOe", 8'h00, ledSinkOe);
    chk1("serialOut", 1'b0, serialOut);
    resetn = 1'b1;
    settle(2);
    chk8("ledSinkOe", 8'h00, ledSinkOe);
    chk1("serialOut", 1'b0, serialOut);
    chk1("eventOverrun", 1'b0, eventOverrun);
    $display("rerun test done");
  endtask
  // every sense bit toggles; sense on a dark sink is no fault
  task automatic t_sense;
    loadWord(8'h55, 8'haa, 8'h15);
    loadWord(8'h55, 8'h55, 8'h75);
    chk1("eventOverrun", 1'b0, eventOverrun);
    $display("sense test done");
  endtask
  initial begin
    resetn = 1'b0;
    outEnableN = 1'b0;
    ledSinkIn = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    t_reset;
    t_shift;
    t_load;
    t_fault;
    t_blank;
    t_track;
    t_rerun;
    t_sense;
    test_done;
  end
  // cut a hang short well inside the cycle budget
  initial begin
    #1_000_000;
    error_cnt++;
    $display("mismatch run expected end seen hang");
    test_done;
  end
endmodule // tb_serial_led_shift_latch
`default_nettype wire
